/* hw/pfic_pkg.sv */
`default_nettype none
// ==========================================
// Constants of the PWM fault and interrupt slice.
package pfic_pkg;
  // ==========================================
  // Register byte addresses.
  localparam logic [31:0] PFIC_FLT_CTRL_ADDR = 32'h001D0038;
  localparam logic [31:0] PFIC_OVF_STAT_ADDR = 32'h001D003C;
  localparam logic [31:0] PFIC_IRQ_ADDR = 32'h001D0040;
  localparam logic [31:0] PFIC_PRESET_ADDR = 32'h001D0044;
  // ==========================================
  // Fault control fields.
  localparam int PFIC_FC_REARM = 31;
  localparam int PFIC_FC_ALL_EN = 30;
  localparam int PFIC_FC_CBC_EN = 29;
  localparam int PFIC_FC_CBC_SRC = 28;
  localparam int PFIC_FC_CBC_LSB = 21;
  localparam int PFIC_RUN_W = 7;
  localparam logic [31:0] PFIC_FC_RST = 32'h0000_0000;
  // ==========================================
  // Overflow and check status fields.
  localparam int PFIC_OV_CHK_B = 7;
  localparam int PFIC_OV_CHK_A = 6;
  localparam int PFIC_OV_PIN_B = 5;
  localparam int PFIC_OV_PIN_A = 4;
  // ==========================================
  // Interrupt register fields.
  localparam int PFIC_IR_DTC = 23;
  localparam int PFIC_IR_MODE = 22;
  localparam int PFIC_IR_FLT_LSB = 18;
  localparam int PFIC_IR_PRD = 17;
  localparam int PFIC_IR_INT = 16;
  localparam int PFIC_IR_RW_LSB = 4;
  localparam int PFIC_RW_CLR = 7;
  localparam int PFIC_RW_MFEN = 6;
  localparam int PFIC_RW_MIEN = 5;
  localparam int PFIC_RW_FLT_LSB = 1;
  localparam int PFIC_RW_PIEN = 0;
  localparam logic [7:0] PFIC_RW_RST = 8'h00;
  localparam logic [3:0] PFIC_SCALE_RST = 4'hF;
  // Last period count for each scale code.
  localparam logic [7:0] PFIC_DIV_LAST [16] = '{
    8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h0F, 8'h1F, 8'h2F,
    8'h3F, 8'h4F, 8'h5F, 8'h7F, 8'h9F, 8'hBF, 8'hDF, 8'hFF};
  // ==========================================
  // Counter preset field.
  localparam int PFIC_PRE_LSB = 4;
  localparam int PFIC_PRE_W = 14;
  // ==========================================
  // Synchroniser lanes of the asynchronous inputs.
  localparam int PFIC_SI_A = 0;
  localparam int PFIC_SI_B = 1;
  localparam int PFIC_SI_AB = 2;
  localparam int PFIC_SI_CRAW = 3;
  localparam int PFIC_SI_CMOD = 4;
  localparam int PFIC_SI_SYNC = 5;
  localparam int PFIC_SI_PINA = 6;
  localparam int PFIC_SI_PINB = 7;
  // ==========================================
  // Whole state of the slice. Fault lanes: 3=A, 2=B, 1=AB, 0=cycle limit.
  typedef struct packed {
    logic [31:0] fc;
    logic [7:0] irw;
    logic [3:0] scale;
    logic [13:0] pre;
    logic [7:0] s1;
    logic [7:0] s2;
    logic sync_p;
    logic [3:0] seen;
    logic [3:0][6:0] cnt;
    logic [3:0] trip;
    logic mode_f;
    logic prd_f;
    logic dtc_f;
    logic [3:0] ovf;
    logic [7:0] pcnt;
    logic irq;
    logic [31:0] rdata;
    logic load;
    logic [13:0] load_val;
    logic en_a;
    logic en_b;
  } pfic_state_t;
endpackage : pfic_pkg
`default_nettype wire

/* hw/pfic_top.sv */
// Implementation choice: the address-and-strobe port.
`default_nettype none
// Summary of operation
// - Rearm bit falling edge re-enables outputs.
// - Global enable gates all fault detection.
// - Cycle limit enable switches its module.
// - Source select: raw or module output.
// - Cycle limit trips after programmed run.
// - Pair fault trips after programmed run.
// - Second fault trips after programmed run.
// - First fault trips after programmed run.
// - Failed check bits; output needs override.
// - Sticky overflow bits for four events.
// - Read-only flags for tuner, mode, faults.
// - Status bit shows the interrupt output.
// - Clear bit rising edge clears mode flag.
// - Mode flag set only while enabled.
// - Per-flag interrupt enables, off at reset.
// - Period interrupt only while enabled.
// - Scale code selects period interrupt rate.
// - Sync with preset enable loads counter.
module pfic_top
  import pfic_pkg::*;
(
  input wire logic sys_clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic [31:0] addr_i, // Register byte address.
  input wire logic [31:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [31:0] rdata_o, // Read data, cycle after read.
  input wire logic first_fault_flag_i, // First fault comparator.
  input wire logic second_fault_flag_i, // Second fault comparator.
  input wire logic pair_fault_flag_i, // Pair fault comparator.
  input wire logic cbc_raw_i, // Raw cycle limit fault.
  input wire logic cbc_mod_i, // Cycle limit module output.
  input wire logic sync_i, // Sync source.
  input wire logic pin_a_i, // PWM A pin level.
  input wire logic pin_b_i, // PWM B pin level.
  input wire logic period_end_i, // End of switching cycle pulse.
  input wire logic chk_a_fail_i, // Output A check failed.
  input wire logic chk_b_fail_i, // Output B check failed.
  input wire logic ovr_a_i, // Override for output A.
  input wire logic ovr_b_i, // Override for output B.
  input wire logic [3:0] ovf_ev_i, // Event overflow pulses.
  input wire logic mode_chg_i, // Mode change pulse.
  input wire logic dtc_off_i, // Dead time tuner off level.
  input wire logic preset_en_i, // Preset enable of control two.
  output logic pwm_a_en_o, // Output A enable.
  output logic pwm_b_en_o, // Output B enable.
  output logic irq_o, // Interrupt output.
  output logic cnt_load_o, // Period counter load pulse.
  output logic [13:0] cnt_load_val_o // Period counter load value.
);

  // ==========================================
  // State and decode.
  pfic_state_t q;
  pfic_state_t d;
  logic wr_fc;
  logic wr_ir;
  logic wr_pre;
  logic rd_ov;
  logic rd_ir;
  logic rearm;
  logic clr_edge;
  logic sync_rise;
  logic cbc_sel;
  logic [3:0] fnow;
  logic [3:0] lane_en;
  logic [3:0] trip_set;
  logic [3:0][6:0] cnt_nxt;
  logic prd_hit;
  logic mode_set;

  // Address decode of the strobes.
  assign wr_fc = wr_i && (addr_i == PFIC_FLT_CTRL_ADDR);
  assign wr_ir = wr_i && (addr_i == PFIC_IRQ_ADDR);
  assign wr_pre = wr_i && (addr_i == PFIC_PRESET_ADDR);
  assign rd_ov = rd_i && (addr_i == PFIC_OVF_STAT_ADDR);
  assign rd_ir = rd_i && (addr_i == PFIC_IRQ_ADDR);

  // Write edges on the rearm and clear bits.
  assign rearm = wr_fc && q.fc[PFIC_FC_REARM] && !wdata_i[PFIC_FC_REARM];
  assign clr_edge = wr_ir && !q.irw[PFIC_RW_CLR]
                    && wdata_i[PFIC_IR_RW_LSB + PFIC_RW_CLR];
  assign sync_rise = q.s2[PFIC_SI_SYNC] && !q.sync_p;
  assign mode_set = mode_chg_i && q.irw[PFIC_RW_MFEN];

  // Cycle limit input source.
  assign cbc_sel = q.fc[PFIC_FC_CBC_SRC] ? q.s2[PFIC_SI_CMOD] : q.s2[PFIC_SI_CRAW];
  assign fnow = {q.s2[PFIC_SI_A], q.s2[PFIC_SI_B], q.s2[PFIC_SI_AB], cbc_sel};

  // Lane enables from the global and cycle limit bits.
  assign lane_en[3] = q.fc[PFIC_FC_ALL_EN];
  assign lane_en[2] = q.fc[PFIC_FC_ALL_EN];
  assign lane_en[1] = q.fc[PFIC_FC_ALL_EN];
  assign lane_en[0] = q.fc[PFIC_FC_ALL_EN] && q.fc[PFIC_FC_CBC_EN];

  // ==========================================
  // Consecutive fault counters, one per lane.
  // A run counts one per switching cycle that saw the fault.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = q.cnt[i];
      trip_set[i] = 1'b0;
      if (!lane_en[i]) begin
        cnt_nxt[i] = 7'h00;
      end else if (period_end_i) begin
        if (q.seen[i] || fnow[i]) begin
          if (q.cnt[i] != 7'h7F) begin
            cnt_nxt[i] = q.cnt[i] + 7'h01;
          end
          // Eight-bit sum, so a saturated run still compares above the field after a rearm.
          trip_set[i] = ({1'b0, q.cnt[i]} + 8'h01)
                        >= {1'b0, q.fc[PFIC_FC_CBC_LSB - PFIC_RUN_W * i +: PFIC_RUN_W]};
        end else begin
          cnt_nxt[i] = 7'h00;
        end
      end
    end
  end

  // Period interrupt divider hit.
  assign prd_hit = period_end_i && (q.pcnt >= PFIC_DIV_LAST[q.scale]);

  // ==========================================
  // Next state.
  always_comb begin
    d = q;
    d.s1 = {pin_b_i, pin_a_i, sync_i, cbc_mod_i, cbc_raw_i, pair_fault_flag_i, second_fault_flag_i, first_fault_flag_i};
    d.s2 = q.s1;
    d.sync_p = q.s2[PFIC_SI_SYNC];
    // Register writes.
    if (wr_fc) begin
      d.fc = wdata_i;
    end
    if (wr_ir) begin
      d.irw = wdata_i[PFIC_IR_RW_LSB +: 8];
      d.scale = wdata_i[3:0];
    end
    if (wr_pre) begin
      d.pre = wdata_i[PFIC_PRE_LSB +: PFIC_PRE_W];
    end
    // Fault runs and latched trips; a new trip wins over rearm.
    d.cnt = cnt_nxt;
    if (period_end_i) begin
      d.seen = 4'h0;
    end else begin
      d.seen = (q.seen | fnow) & lane_en;
    end
    d.trip = (rearm ? 4'h0 : q.trip) | trip_set;
    // Output enables follow the trips and the checks.
    d.en_a = (d.trip == 4'h0) && (!chk_a_fail_i || ovr_a_i);
    d.en_b = (d.trip == 4'h0) && (!chk_b_fail_i || ovr_b_i);
    // Mode change flag; a new event wins over the clear.
    d.mode_f = (clr_edge ? 1'b0 : q.mode_f) | mode_set;
    d.dtc_f = dtc_off_i;
    // Overflow bits stick until read; a new event wins.
    d.ovf = (rd_ov ? 4'h0 : q.ovf) | ovf_ev_i;
    // Period divider and its sticky flag, cleared by reading.
    if (period_end_i) begin
      d.pcnt = prd_hit ? 8'h00 : q.pcnt + 8'h01;
    end
    d.prd_f = (rd_ir ? 1'b0 : q.prd_f) | (prd_hit && q.irw[PFIC_RW_PIEN]);
    // Interrupt is any enabled flag.
    d.irq = (d.mode_f && d.irw[PFIC_RW_MIEN])
            || ((d.trip & d.irw[PFIC_RW_FLT_LSB +: 4]) != 4'h0)
            || d.prd_f;
    // Counter preset on sync.
    d.load = sync_rise && preset_en_i;
    if (sync_rise && preset_en_i) begin
      d.load_val = q.pre;
    end
    // Read data, zero for unmapped addresses.
    d.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        PFIC_FLT_CTRL_ADDR: d.rdata = q.fc;
        PFIC_OVF_STAT_ADDR: begin
          d.rdata[PFIC_OV_CHK_B] = chk_b_fail_i;
          d.rdata[PFIC_OV_CHK_A] = chk_a_fail_i;
          d.rdata[PFIC_OV_PIN_B] = q.s2[PFIC_SI_PINB];
          d.rdata[PFIC_OV_PIN_A] = q.s2[PFIC_SI_PINA];
          d.rdata[3:0] = q.ovf;
        end
        PFIC_IRQ_ADDR: begin
          d.rdata[PFIC_IR_DTC] = q.dtc_f;
          d.rdata[PFIC_IR_MODE] = q.mode_f;
          d.rdata[PFIC_IR_FLT_LSB +: 4] = q.trip;
          d.rdata[PFIC_IR_PRD] = q.prd_f;
          d.rdata[PFIC_IR_INT] = q.irq;
          d.rdata[PFIC_IR_RW_LSB +: 8] = q.irw;
          d.rdata[3:0] = q.scale;
        end
        PFIC_PRESET_ADDR: d.rdata[PFIC_PRE_LSB +: PFIC_PRE_W] = q.pre;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.fc <= PFIC_FC_RST;
      q.irw <= PFIC_RW_RST;
      q.scale <= PFIC_SCALE_RST;
      q.en_a <= 1'b1;
      q.en_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata_o = q.rdata;
  assign pwm_a_en_o = q.en_a;
  assign pwm_b_en_o = q.en_b;
  assign irq_o = q.irq;
  assign cnt_load_o = q.load;
  assign cnt_load_val_o = q.load_val;

  // ==========================================
  // Checks.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Rearm with no new trip clears all trips and the output A enable returns.
  property p_rearm;
    rearm && (trip_set == 4'h0) && !chk_a_fail_i |=> (q.trip == 4'h0) && q.en_a;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("rearm did not re-enable output");

  // Trips persist while no falling rearm edge is written.
  property p_hold;
    (q.trip != 4'h0) && !rearm |=> q.trip != 4'h0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("trip lost without rearm");

  // Without the global enable no trip appears.
  property p_gate;
    !q.fc[PFIC_FC_ALL_EN] && (q.trip == 4'h0) |=> q.trip == 4'h0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("trip while faults disabled");

  // A trip keeps both outputs off.
  property p_off;
    q.trip != 4'h0 |-> !q.en_a && !q.en_b;
  endproperty
  a_off: assert property (p_off)
    else $error("output enabled during trip");

  // Interrupt equals the enabled flags.
  property p_irq;
    q.irq == ((q.mode_f && q.irw[PFIC_RW_MIEN])
              || ((q.trip & q.irw[PFIC_RW_FLT_LSB +: 4]) != 4'h0) || q.prd_f);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match flags");

  // Clear edge without a new event clears the mode flag.
  property p_clr;
    clr_edge && !mode_set |=> !q.mode_f;
  endproperty
  a_clr: assert property (p_clr)
    else $error("mode flag not cleared");

  // Mode flag stays off while its enable is off.
  property p_mode;
    !q.irw[PFIC_RW_MFEN] && !q.mode_f |=> !q.mode_f;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode flag set while disabled");

  // Period flag stays off while its enable is off.
  property p_prd;
    !q.irw[PFIC_RW_PIEN] && !q.prd_f |=> !q.prd_f;
  endproperty
  a_prd: assert property (p_prd)
    else $error("period flag set while disabled");

  // Sync with preset enable loads the preset one cycle later.
  property p_load;
    sync_rise && preset_en_i |=> q.load && (q.load_val == $past(q.pre));
  endproperty
  a_load: assert property (p_load)
    else $error("preset not loaded on sync");

  // A cycle without a fault on lane A zeroes its run.
  property p_run;
    period_end_i && !q.seen[3] && !fnow[3] |=> q.cnt[3] == 7'h00;
  endproperty
  a_run: assert property (p_run)
    else $error("run counter not reset");

  // Interrupt status bit reads the interrupt output.
  property p_intbit;
    rd_ir |=> rdata_o[PFIC_IR_INT] == $past(q.irq);
  endproperty
  a_intbit: assert property (p_intbit)
    else $error("interrupt status bit wrong");

  // Without the cycle limit enable its lane never trips.
  property p_cbc_gate;
    !q.fc[PFIC_FC_CBC_EN] && !q.trip[0] |=> !q.trip[0];
  endproperty
  a_cbc_gate: assert property (p_cbc_gate)
    else $error("cycle limit trip while its module is off");

  // Every overflow pulse leaves its sticky bit set.
  property p_ovf;
    ovf_ev_i != 4'h0 |=> (q.ovf & $past(ovf_ev_i)) == $past(ovf_ev_i);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow event not latched");

  // No load pulse without an enabled sync edge.
  property p_noload;
    !(sync_rise && preset_en_i) |=> !q.load;
  endproperty
  a_noload: assert property (p_noload)
    else $error("counter load without sync");

  // A failed check without override keeps output A off.
  property p_chk_a;
    chk_a_fail_i && !ovr_a_i |=> !q.en_a;
  endproperty
  a_chk_a: assert property (p_chk_a)
    else $error("failed output A enabled without override");

  // Writing the clear bit while it is already stored leaves the flag alone.
  property p_keep;
    wr_ir && q.irw[PFIC_RW_CLR] && q.mode_f |=> q.mode_f;
  endproperty
  a_keep: assert property (p_keep)
    else $error("mode flag cleared without rising clear");

  // An enabled mode change always sets the flag.
  property p_mode_set;
    mode_set |=> q.mode_f;
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("enabled mode change not flagged");

endmodule : pfic_top
`default_nettype wire

/* sim/pfic_far_model.sv */
`default_nettype none
// ==========================================
// Far side: fault comparators, pin levels, sync source and switching cycles.
module pfic_far_model (
  input wire logic clk_i, // System clock.
  output logic [4:0] flt_o, // Faults: A, B, AB, raw and module cycle limit.
  output logic sync_o, // Sync source.
  output logic pin_a_o, // PWM A pin level.
  output logic pin_b_o, // PWM B pin level.
  output logic prd_end_o // End of switching cycle pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Comparators idle low, so a released line reads as no fault.
  initial begin
    flt_o = '0;
    sync_o = 0;
    pin_a_o = 0;
    pin_b_o = 0;
    prd_end_o = 0;
  end
  // Cycles of len clocks; the fault drops early so it never leaks into the next cycle.
  task automatic cycles(input int n, input logic [4:0] f, input int len);
    repeat (n) begin
      flt_o <= f;
      repeat (3) @(posedge clk_i);
      flt_o <= '0;
      repeat (len - 4) @(posedge clk_i);
      prd_end_o <= 1;
      @(posedge clk_i);
      prd_end_o <= 0;
    end
  endtask : cycles
  // Sync stays high for four clocks, then the source rests.
  task automatic sync_pulse();
    sync_o <= 1;
    repeat (4) @(posedge clk_i);
    sync_o <= 0;
    repeat (8) @(posedge clk_i);
  endtask : sync_pulse
  // Pin levels change only when asked.
  task automatic pins(input logic a, input logic b);
    pin_a_o <= a;
    pin_b_o <= b;
  endtask : pins
endmodule : pfic_far_model
`default_nettype wire

/* sim/pfic_top_tb.sv */
`default_nettype none
// ==========================================
// Self-checking bench of the PWM fault and interrupt slice.
module pfic_top_tb
  import pfic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FC = PFIC_FLT_CTRL_ADDR;
  localparam logic [31:0] OV = PFIC_OVF_STAT_ADDR;
  localparam logic [31:0] IR = PFIC_IRQ_ADDR;
  localparam logic [31:0] PR = PFIC_PRESET_ADDR;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, chk_a = 0, chk_b = 0, ovr_a = 0, ovr_b = 0;
  logic mode_chg = 0, dtc_off = 0, pre_en = 0, sync, pin_a, pin_b, prd_end, en_a, en_b, irq, load;
  logic [31:0] addr = '0, wdata = '0, rdata;
  logic [3:0] ovf = '0;
  logic [4:0] flt;
  logic [13:0] load_val;
  int err_total = 0, samples_checked = 0, n, h;
  // Switching cycles per period interrupt for each divider code.
  int nper [16] = '{1, 2, 4, 6, 8, 16, 32, 48, 64, 80, 96, 128, 160, 192, 224, 256};
  // Per lane: control word, fault lines raised, expected trips A, B, AB, cycle limit.
  logic [31:0] lane_fc [7] = '{32'h40000080, 32'h40004000, 32'h40200000, 32'h60200000,
    32'h70200000, 32'h70200000, 32'h00000080};
  logic [4:0] lane_f [7] = '{5'h02, 5'h04, 5'h08, 5'h08, 5'h08, 5'h10, 5'h02};
  logic [3:0] lane_x [7] = '{4'h4, 4'h2, 4'h0, 4'h1, 4'h0, 4'h1, 4'h0};

  pfic_far_model far (.clk_i(clk), .flt_o(flt), .sync_o(sync), .pin_a_o(pin_a), .pin_b_o(pin_b),
    .prd_end_o(prd_end));
  pfic_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .first_fault_flag_i(flt[0]), .second_fault_flag_i(flt[1]), .pair_fault_flag_i(flt[2]),
    .cbc_raw_i(flt[3]), .cbc_mod_i(flt[4]), .sync_i(sync), .pin_a_i(pin_a), .pin_b_i(pin_b),
    .period_end_i(prd_end), .chk_a_fail_i(chk_a), .chk_b_fail_i(chk_b), .ovr_a_i(ovr_a),
    .ovr_b_i(ovr_b), .ovf_ev_i(ovf), .mode_chg_i(mode_chg), .dtc_off_i(dtc_off),
    .preset_en_i(pre_en), .pwm_a_en_o(en_a), .pwm_b_en_o(en_b), .irq_o(irq), .cnt_load_o(load),
    .cnt_load_val_o(load_val));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // ==========================================
  // Bus and compare helpers; all waits end just after an edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1;
    @(posedge clk);
    wr_s <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    addr <= a;
    rd_s <= 1;
    @(posedge clk);
    rd_s <= 0;
    #1;
    v = rdata;
  endtask : rd
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), e, v & m);
  endtask : rc
  task automatic ens(input logic [1:0] e);
    tick(2);
    chk("en_ab", e, {en_a, en_b});
  endtask : ens
  task automatic mp();
    mode_chg <= 1;
    @(posedge clk);
    mode_chg <= 0;
    tick(2);
  endtask : mp
  // Counts switching cycles until the interrupt shows, then clears the flag by a read.
  task automatic gap(output int k);
    logic [31:0] v;
    k = 0;
    do begin
      far.cycles(1, 5'h00, 4);
      k++;
      tick(2);
    end while (irq !== 1'b1 && k < 300);
    rd(IR, v);
  endtask : gap
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    tick(1);
    rc(FC, '1, 32'h0);
    rc(OV, 32'hFF, 32'h0);
    rc(IR, '1, 32'hF);
    rc(PR, '1, 32'h0);
    rc(32'h001D0048, '1, 32'h0);
    wr(FC, 32'h0ABCDEF5);
    wr(PR, '1);
    wr(OV, '1);
    wr(32'h001D0048, 32'h0);
    rc(FC, '1, 32'h0ABCDEF5);
    rc(PR, '1, 32'h3FFF0);
    rc(OV, 32'hFF, 32'h0);
    // The B, pair and cycle limit lanes and gates, each with its interrupt enable on.
    wr(IR, 32'h1EF);
    for (int i = 0; i < 7; i++) begin
      wr(FC, lane_fc[i]);
      far.cycles(1, lane_f[i], 8);
      ens(lane_x[i] != 0 ? 2'h0 : 2'h3);
      rc(IR, 32'h3F0000, {lane_x[i], 1'b0, |lane_x[i], 16'h0});
      wr(FC, lane_fc[i] | 32'h80000000);
      wr(FC, lane_fc[i]);
      ens(2'h3);
    end
    // A run of two; a clean cycle breaks the run.
    wr(FC, 32'h40000002);
    far.cycles(1, 5'h01, 8);
    far.cycles(1, 5'h00, 12);
    far.cycles(1, 5'h01, 12);
    ens(2'h3);
    far.cycles(1, 5'h01, 8);
    ens(2'h0);
    wr(FC, 32'h40000002);
    ens(2'h0);
    wr(FC, 32'hC0000002);
    ens(2'h0);
    wr(FC, 32'h40000002);
    ens(2'h3);
    rc(IR, 32'h3F0000, 32'h0);
    // Mode change flag: enable, clear edge, stored clear bit.
    wr(IR, 32'h20F);
    mp();
    rc(IR, 32'h410000, 32'h0);
    wr(IR, 32'h60F);
    mp();
    rc(IR, 32'h410000, 32'h410000);
    wr(IR, 32'hE0F);
    rc(IR, 32'h410000, 32'h0);
    mp();
    wr(IR, 32'hE0F);
    rc(IR, 32'h400000, 32'h400000);
    wr(IR, 32'h60F);
    wr(IR, 32'hE0F);
    rc(IR, 32'h400000, 32'h0);
    // Output checks, overrides, pin mirrors and the tuner flag.
    for (int x = 0; x < 2; x++) begin
      chk_a <= !x[0];
      chk_b <= x[0];
      ovr_a <= 0;
      ovr_b <= 0;
      dtc_off <= !x[0];
      far.pins(!x[0], x[0]);
      tick(4);
      ens(x[0] ? 2'h2 : 2'h1);
      rc(OV, 32'hF0, x[0] ? 32'hA0 : 32'h50);
      rc(IR, 32'h800000, x[0] ? 32'h0 : 32'h800000);
      ovr_a <= 1;
      ovr_b <= 1;
      ens(2'h3);
    end
    // Sticky overflow bits clear on read.
    for (int v = 5; v < 16; v += 5) begin
      ovf <= v[3:0];
      @(posedge clk);
      ovf <= 4'h0;
      tick(1);
      rc(OV, 32'hF, v);
      rc(OV, 32'hF, 32'h0);
    end
    // Counter preset loads on sync only while enabled.
    wr(PR, 32'h12345);
    rc(PR, '1, 32'h12340);
    for (int e = 1; e >= 0; e--) begin
      pre_en <= e[0];
      h = 0;
      fork
        far.sync_pulse();
        repeat (12) begin
          @(posedge clk);
          #1;
          h += (load === 1'b1);
        end
      join
      chk("loads", e, h);
    end
    chk("load_val", 32'h1234, {18'h0, load_val});
    // Period interrupt: off while disabled, then every divider code.
    wr(IR, 32'h0);
    far.cycles(3, 5'h00, 8);
    rc(IR, 32'h30000, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(IR, 32'h10 | c);
      gap(n);
      gap(n);
      chk("period", nper[c], n);
    end
    final_report();
  end

  // Watchdog well beyond the roughly 16000 cycles the sequence needs.
  initial begin
    #(4 * 100000);
    err_total++;
    final_report();
  end
endmodule : pfic_top_tb
`default_nettype wire
